// file: rtl/short_fault_pkg.sv
// short-fault flag bank: shared offsets, layouts, types and reset values
// assumes one 250 MHz clock and a synchronous active-high reset
package short_fault_pkg;

	////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_SHORT_CD = 8'hAC;
	localparam logic [7:0] IDX_SHORT_EF = 8'hAD;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hB0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;
	localparam logic [1:0] WORD_LSBS    = 2'h0;

	////////////////////////////////////////////////////////////////////
	// field positions inside one 8-bit flag register
	localparam int LO_GRP_LSB = 0;
	localparam int HI_GRP_LSB = 4;
	localparam int RSV_LO_BIT = 3;
	localparam int RSV_HI_BIT = 7;
	localparam int CH_PER_GRP = 3;
	localparam int FLAG_W     = 8;
	localparam int STAT_W     = 16;

	// reset values
	localparam logic [FLAG_W-1:0] FLAG_RST  = 8'h00;
	localparam logic [STAT_W-1:0] STAT_RST  = 16'h0000;
	localparam logic [STAT_W-1:0] MASK_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] UNMAPPED  = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_e;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0]   byteenable;
	} avs_req_s;

	// channel 2 in the top bit of each group
	typedef struct packed {
		logic [CH_PER_GRP-1:0] grp_f;
		logic [CH_PER_GRP-1:0] grp_e;
		logic [CH_PER_GRP-1:0] grp_d;
		logic [CH_PER_GRP-1:0] grp_c;
	} short_detect_s;

	typedef struct packed {
		short_detect_s flags;
		short_detect_s rise;
	} capture_state_s;

	typedef struct packed {
		bus_state_e        bus;
		logic              wait_req;
		logic [DATA_W-1:0] rdata;
		logic [STAT_W-1:0] stat;
		logic [STAT_W-1:0] mask;
		logic              irq;
	} bank_state_s;

endpackage

// file: rtl/short_fault_capture.sv
// short-fault capture: registers the per-channel detect levels
// assumes detect inputs are synchronous to i_clock
`timescale 1ns/1ps
module short_fault_capture (
	// clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_sys_rst,
	// comparator side
	input  wire short_fault_pkg::short_detect_s i_detect,
	// bank side
	output      short_fault_pkg::short_detect_s o_flags,
	output      short_fault_pkg::short_detect_s o_rise
);
	import short_fault_pkg::*;

	capture_state_s st_q;
	capture_state_s st_d;

	////////////////////////////////////////////////////////////////////
	// flag follows the comparator; rise marks a newly found short
	always_comb begin
		st_d       = st_q;
		st_d.flags = i_detect;
		st_d.rise  = i_detect & ~st_q.flags;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_flags = st_q.flags;
	assign o_rise  = st_q.rise;

	////////////////////////////////////////////////////////////////////
	flag_tracks_detect_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!$past(i_sys_rst) |-> o_flags == $past(i_detect))
	else $error("flag does not follow detect");

	flags_reset_zero_a:
	assert property (@(posedge i_clock)
		$past(i_sys_rst) |-> (o_flags == '0 && o_rise == '0))
	else $error("flags not zero after reset");

endmodule

// file: rtl/output_short_fault_flags.sv
// short-fault flag bank for output groups c to f, with an Avalon-MM slave
// assumes a 250 MHz clock, synchronous reset, byte addressing on the bus
`timescale 1ns/1ps
module output_short_fault_flags (
	// clock and reset
	input  wire logic                                 i_clock,
	input  wire logic                                 i_sys_rst,
	// avalon-mm slave
	input  wire short_fault_pkg::avs_req_s            i_avs,
	output logic [short_fault_pkg::DATA_W-1:0]        o_avs_readdata,
	output logic                                      o_avs_waitrequest,
	// diagnostic comparators
	input  wire short_fault_pkg::short_detect_s       i_short_detect,
	// interrupt
	output logic                                      o_irq
);
	import short_fault_pkg::*;

	////////////////////////////////////////////////////////////////////
	// capture of the comparator levels

	short_detect_s flags;
	short_detect_s rise;

	short_fault_capture u_capture (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_detect  (i_short_detect),
		.o_flags   (flags),
		.o_rise    (rise)
	);

	////////////////////////////////////////////////////////////////////
	// register layout: high group in 6:4, low group in 2:0

	function automatic logic [FLAG_W-1:0] pack_pair(
		input logic [CH_PER_GRP-1:0] hi,
		input logic [CH_PER_GRP-1:0] lo
	);
		logic [FLAG_W-1:0] v;
		v = FLAG_RST;
		v[HI_GRP_LSB +: CH_PER_GRP] = hi;
		v[LO_GRP_LSB +: CH_PER_GRP] = lo;
		v[RSV_HI_BIT] = 1'b0;
		v[RSV_LO_BIT] = 1'b0;
		return v;
	endfunction

	logic [FLAG_W-1:0] reg_cd;
	logic [FLAG_W-1:0] reg_ef;
	logic [STAT_W-1:0] rise_vec;

	assign reg_cd   = pack_pair(flags.grp_d, flags.grp_c);
	assign reg_ef   = pack_pair(flags.grp_f, flags.grp_e);
	assign rise_vec = {pack_pair(rise.grp_f, rise.grp_e),
	                   pack_pair(rise.grp_d, rise.grp_c)};

	////////////////////////////////////////////////////////////////////
	// address decode

	logic [7:0] idx;
	logic       aligned;
	logic       req;
	logic       hit_cd;
	logic       hit_ef;
	logic       hit_stat;
	logic       hit_mask;

	assign idx      = i_avs.address[ADDR_W-1:2];
	assign aligned  = (i_avs.address[1:0] == WORD_LSBS);
	assign req      = i_avs.read | i_avs.write;
	assign hit_cd   = aligned && (idx == IDX_SHORT_CD);
	assign hit_ef   = aligned && (idx == IDX_SHORT_EF);
	assign hit_stat = aligned && (idx == IDX_IRQ_STAT);
	assign hit_mask = aligned && (idx == IDX_IRQ_MASK);

	////////////////////////////////////////////////////////////////////
	// state

	bank_state_s st_q;
	bank_state_s st_d;

	logic              accept;
	logic              wr_stat;
	logic              wr_mask;
	logic [STAT_W-1:0] lane_mask;
	logic [STAT_W-1:0] clr;
	logic [DATA_W-1:0] rmux;

	// a request is taken at the edge where waitrequest is seen low
	assign accept  = req && (st_q.bus == BUS_ACK);
	assign wr_stat = accept && i_avs.write && hit_stat;
	assign wr_mask = accept && i_avs.write && hit_mask;

	assign lane_mask = {{8{i_avs.byteenable[1]}},
	                    {8{i_avs.byteenable[0]}}};
	assign clr = wr_stat ? (i_avs.writedata[STAT_W-1:0] & lane_mask)
	                     : STAT_RST;

	// read mux; flag registers are read-only, so writes there are dropped
	always_comb begin
		rmux = UNMAPPED;
		if (hit_cd) begin
			rmux[FLAG_W-1:0] = reg_cd;
		end else if (hit_ef) begin
			rmux[FLAG_W-1:0] = reg_ef;
		end else if (hit_stat) begin
			rmux[STAT_W-1:0] = st_q.stat;
		end else if (hit_mask) begin
			rmux[STAT_W-1:0] = st_q.mask;
		end
	end

	always_comb begin
		st_d = st_q;
		case (st_q.bus)
			BUS_IDLE: begin
				if (req) begin
					st_d.bus      = BUS_ACK;
					st_d.wait_req = 1'b0;
					st_d.rdata    = i_avs.read ? rmux : RDATA_RST;
				end
			end
			BUS_ACK: begin
				st_d.bus      = BUS_IDLE;
				st_d.wait_req = 1'b1;
			end
			default: begin
				st_d.bus      = BUS_IDLE;
				st_d.wait_req = 1'b1;
			end
		endcase

		// new shorts win over a clear in the same cycle
		st_d.stat = (st_q.stat & ~clr) | rise_vec;
		if (wr_mask) begin
			st_d.mask = (st_q.mask & ~lane_mask) |
			            (i_avs.writedata[STAT_W-1:0] & lane_mask);
		end
		st_d.irq = |(st_d.stat & st_d.mask);
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			st_q.bus      <= BUS_IDLE;
			st_q.wait_req <= 1'b1;
			st_q.rdata    <= RDATA_RST;
			st_q.stat     <= STAT_RST;
			st_q.mask     <= MASK_RST;
			st_q.irq      <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_avs_readdata    = st_q.rdata;
	assign o_avs_waitrequest = st_q.wait_req;
	assign o_irq             = st_q.irq;

	////////////////////////////////////////////////////////////////////
	// checks

	logic rd_cd_go;
	logic rd_ef_go;

	assign rd_cd_go = (st_q.bus == BUS_IDLE) && i_avs.read && hit_cd;
	assign rd_ef_go = (st_q.bus == BUS_IDLE) && i_avs.read && hit_ef;

	logic rd_stat_go;
	logic rd_miss_go;
	logic wr_any_go;

	assign rd_stat_go = (st_q.bus == BUS_IDLE) && i_avs.read && hit_stat;
	assign rd_miss_go = (st_q.bus == BUS_IDLE) && i_avs.read &&
	                    !(hit_cd || hit_ef || hit_stat || hit_mask);
	assign wr_any_go  = (st_q.bus == BUS_IDLE) && i_avs.write;

	grp_d_bits_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_cd_go |=> o_avs_readdata[6:4] == $past(flags.grp_d))
	else $error("group d flags misplaced");

	grp_c_bits_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_cd_go |=> (o_avs_readdata[2:0] == $past(flags.grp_c))
		and !o_avs_waitrequest)
	else $error("group c flags misplaced");

	grp_f_bits_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_ef_go |=> o_avs_readdata[6:4] == $past(flags.grp_f))
	else $error("group f flags misplaced");

	grp_e_bits_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_ef_go |=> o_avs_readdata[2:0] == $past(flags.grp_e))
	else $error("group e flags misplaced");

	short_reads_one_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_cd_go && i_short_detect.grp_c[0] && flags.grp_c[0]
		|=> o_avs_readdata[0])
	else $error("detected short reads zero");

	reset_reads_zero_a:
	assert property (@(posedge i_clock)
		$past(i_sys_rst) |-> (reg_cd == FLAG_RST && reg_ef == FLAG_RST
		&& o_avs_readdata == RDATA_RST && o_avs_waitrequest))
	else $error("bank not cleared by reset");

	reserved_zero_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(rd_cd_go || rd_ef_go) |=>
		o_avs_readdata[DATA_W-1:RSV_HI_BIT] == '0 &&
		!o_avs_readdata[RSV_LO_BIT])
	else $error("reserved bits read nonzero");

	flag_write_inert_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		accept && i_avs.write && (hit_cd || hit_ef) |=>
		st_q.mask == $past(st_q.mask) &&
		st_q.stat == ($past(st_q.stat) | $past(rise_vec)))
	else $error("write to flag register had an effect");

	bus_answers_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		req && o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest)
	else $error("waitrequest never dropped");

	set_beats_clear_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		|rise_vec |=> (st_q.stat & $past(rise_vec)) == $past(rise_vec))
	else $error("event lost against clear");

	irq_level_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		##1 o_irq == |(st_q.stat & st_q.mask))
	else $error("irq does not match status and mask");

	wait_one_cycle_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!o_avs_waitrequest |=> o_avs_waitrequest)
	else $error("waitrequest low for more than one cycle");

	rdata_holds_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$changed(o_avs_readdata) |-> !o_avs_waitrequest)
	else $error("read data changed outside an answer");

	write_reads_zero_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_any_go |=> o_avs_readdata == RDATA_RST)
	else $error("write answer carries data");

	miss_reads_zero_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_miss_go |=> o_avs_readdata == UNMAPPED)
	else $error("unmapped read returns data");

	stat_readback_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rd_stat_go |=> o_avs_readdata[DATA_W-1:STAT_W] == '0 &&
		o_avs_readdata[STAT_W-1:0] == $past(st_q.stat))
	else $error("status reads back wrong");

	stat_sticky_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!wr_stat |=> (st_q.stat & $past(st_q.stat)) == $past(st_q.stat))
	else $error("status bit lost without a clear");

	stat_clear_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_stat |=> (st_q.stat & ~$past(rise_vec) &
		$past(i_avs.writedata[STAT_W-1:0] & lane_mask)) == '0)
	else $error("written one did not clear status");

	stat_rsv_zero_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!st_q.stat[RSV_LO_BIT] && !st_q.stat[RSV_HI_BIT] &&
		!st_q.stat[FLAG_W+RSV_LO_BIT] && !st_q.stat[FLAG_W+RSV_HI_BIT])
	else $error("reserved status bit set");

	mask_hold_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!wr_mask |=> $stable(st_q.mask))
	else $error("mask changed without a write");

	mask_write_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_mask |=> (st_q.mask & $past(lane_mask)) ==
		$past(i_avs.writedata[STAT_W-1:0] & lane_mask))
	else $error("mask write did not land");

	irq_on_rise_a:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		|(rise_vec & st_q.mask) && !wr_mask |=> o_irq)
	else $error("unmasked event did not raise irq");

endmodule

// file: tb/output_short_fault_flags_tb.sv
// testbench for the short-fault flag bank, driven over avalon-mm
// assumes the package of the bank and a 250 MHz clock, no partner model
`timescale 1ns/1ps
module output_short_fault_flags_tb;
	import short_fault_pkg::*;

	localparam logic [ADDR_W-1:0] A_CD   = 10'h2b0;
	localparam logic [ADDR_W-1:0] A_EF   = 10'h2b4;
	localparam logic [ADDR_W-1:0] A_STAT = 10'h2c0;
	localparam logic [ADDR_W-1:0] A_MASK = 10'h2c4;

	logic              clock;
	logic              sys_rst;
	avs_req_s          avs;
	logic [DATA_W-1:0] rdata;
	logic              wreq;
	logic              irq;
	short_detect_s     det;
	logic [DATA_W-1:0] q;
	int                miscompares;
	int                tests_run;

	output_short_fault_flags i_dut (
		.i_clock           (clock),
		.i_sys_rst         (sys_rst),
		.i_avs             (avs),
		.o_avs_readdata    (rdata),
		.o_avs_waitrequest (wreq),
		.i_short_detect    (det),
		.o_irq             (irq)
	);

	always #2 clock = ~clock;

	////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [DATA_W-1:0] seen,
			input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// one bus cycle; holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
		avs.read       <= !wr;
		avs.write      <= wr;
		avs.address    <= a;
		avs.writedata  <= d;
		avs.byteenable <= be;
		do begin
			@(posedge clock);
		end while (wreq !== 1'b0);
		q = rdata;
		avs.read  <= 1'b0;
		avs.write <= 1'b0;
		@(posedge clock);
	endtask

	function automatic logic [DATA_W-1:0] exp_cd(input short_detect_s s);
		return {24'h00_0000, 1'b0, s.grp_d, 1'b0, s.grp_c};
	endfunction

	function automatic logic [DATA_W-1:0] exp_ef(input short_detect_s s);
		return {24'h00_0000, 1'b0, s.grp_f, 1'b0, s.grp_e};
	endfunction

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic test_reset();
		bus(1'b0, A_CD, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, A_EF, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, A_STAT, '0, 4'hf);
		check(q, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
	endtask

	// walking one through every channel of every group
	task automatic test_map();
		short_detect_s e;
		for (int k = 0; k < 12; k++) begin
			e = short_detect_s'(12'h001 << k);
			det <= e;
			repeat (2) @(posedge clock);
			bus(1'b0, A_CD, '0, 4'hf);
			check(q, exp_cd(e));
			bus(1'b0, A_EF, '0, 4'hf);
			check(q, exp_ef(e));
		end
		det <= short_detect_s'(12'hfff);
		repeat (2) @(posedge clock);
		bus(1'b0, A_CD, '0, 4'hf);
		check(q, 32'h0000_0077);
		bus(1'b0, A_EF, '0, 4'hf);
		check(q, 32'h0000_0077);
	endtask

	task automatic test_ro();
		short_detect_s e;
		e = short_detect_s'(12'h5a5);
		det <= e;
		repeat (2) @(posedge clock);
		bus(1'b1, A_CD, 32'hffff_ffff, 4'hf);
		bus(1'b1, A_EF, 32'h0000_0000, 4'hf);
		bus(1'b0, A_CD, '0, 4'hf);
		check(q, exp_cd(e));
		bus(1'b0, A_EF, '0, 4'hf);
		check(q, exp_ef(e));
	endtask

	task automatic test_irq();
		bus(1'b0, A_STAT, '0, 4'hf);
		check(q, 32'h0000_7777);
		check({31'h0, irq}, 32'h0000_0000);
		bus(1'b1, A_MASK, 32'h0000_0100, 4'hf);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h0000_0001);
		bus(1'b1, A_STAT, 32'h0000_0100, 4'hf);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h0000_0000);
		bus(1'b0, A_STAT, '0, 4'hf);
		check(q, 32'h0000_7677);
		bus(1'b1, A_STAT, 32'h0000_ffff, 4'h1);
		bus(1'b0, A_STAT, '0, 4'hf);
		check(q, 32'h0000_7600);
		bus(1'b0, A_MASK, '0, 4'hf);
		check(q, 32'h0000_0100);
	endtask

	task automatic test_unmapped();
		bus(1'b1, 10'h100, 32'hffff_ffff, 4'hf);
		bus(1'b0, 10'h100, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, 10'h2b1, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, A_CD, '0, 4'hf);
		check(q, exp_cd(det));
	endtask

	// a short that rises while its status bit is cleared keeps the bit
	task automatic test_set_wins();
		det <= '0;
		repeat (2) @(posedge clock);
		det <= short_detect_s'(12'h080);
		bus(1'b1, A_STAT, 32'h0000_0600, 4'hf);
		bus(1'b0, A_STAT, '0, 4'hf);
		check(q, 32'h0000_7200);
		check({31'h0, irq}, 32'h0000_0000);
		bus(1'b0, A_EF, '0, 4'hf);
		check(q, 32'h0000_0002);
	endtask

	// reset in mid-run clears flags, sticky status and mask
	task automatic test_rerst();
		det     <= '0;
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		bus(1'b0, A_CD, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, A_EF, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, A_STAT, '0, 4'hf);
		check(q, 32'h0000_0000);
		bus(1'b0, A_MASK, '0, 4'hf);
		check(q, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		miscompares = 0;
		tests_run   = 0;
		clock       = 1'b0;
		sys_rst     = 1'b1;
		avs         = '0;
		det         = '0;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		test_reset();
		test_map();
		test_ro();
		test_irq();
		test_unmapped();
		test_set_wins();
		test_rerst();
		give_verdict();
	end

	initial begin
		#80000;
		miscompares++;
		give_verdict();
	end

endmodule
